// [daq_far_side_model.sv]
// Converter front end and bus-master sink facing the DAQ block
module daq_far_side_model (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic conv_busy_in,
  input wire logic [daq_pkg::SAMPLE_W-1:0] sample_value_in,
  input wire logic stall_in,
  input wire logic dma_valid_in,
  input wire logic [daq_pkg::RESULT_W-1:0] dma_data_in,
  output logic [daq_pkg::SAMPLE_W-1:0] adc_sample_out,
  output logic dma_ready_out,
  output int words_out,
  output logic [daq_pkg::RESULT_W-1:0] last_word_out
);
  import daq_pkg::*;
  logic slow;
  // Outside a conversion the lines wander, so a mistimed capture shows up
  assign adc_sample_out = conv_busy_in ? sample_value_in : ~sample_value_in ^ {11'h000, slow};
  // A slow sink: takes a word only every second cycle
  assign dma_ready_out = !stall_in && slow;
  always @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      slow <= 1'b0;
      words_out <= 0;
      last_word_out <= 16'h0000;
    end else begin
      slow <= !slow;
      if (dma_valid_in === 1'b1 && dma_ready_out) begin
        words_out <= words_out + 1;
        last_word_out <= dma_data_in;
      end
    end
  end
endmodule

// [daq_pkg.sv]
// Shared constants, field layout and types of the DAQ trigger, transfer and digital I/O block
package daq_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int SAMPLE_W = 12;
  localparam int CHAN_W = 4;
  localparam int RESULT_W = SAMPLE_W + CHAN_W;
  localparam int PORT_W = 16;
  localparam int CTR_W = 16;

  localparam logic [ADDR_W-1:0] OFS_CTR0 = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_CTR1 = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_CTR2 = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_TCTRL = 6'h0C;
  localparam logic [ADDR_W-1:0] OFS_AD_DATA = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_DAC_TWO = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_AD_CTRL = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_DIO = 6'h1C;
  localparam logic [ADDR_W-1:0] OFS_KICK = 6'h20;

  // A/D control word
  localparam int BIT_BUS_MASTER = 0;
  localparam int BIT_IRQ_XFER = 1;
  localparam int BIT_PACER = 2;
  localparam int BIT_EXT_SRC = 3;
  localparam int BIT_AUTOSCAN = 4;
  localparam int MUX_LSB = 5;
  localparam int GAIN_LSB = 9;
  // Status word
  localparam int BIT_DONE = 0;
  localparam int BIT_OVERRUN = 1;
  // Result word
  localparam int TAG_LSB = 0;
  localparam int VALUE_LSB = 4;
  // Timer control byte
  localparam int SC_LSB = 6;
  localparam int RL_LSB = 4;
  localparam int TMODE_LSB = 1;
  localparam logic [1:0] RL_LATCH = 2'h0;
  localparam logic [1:0] RL_LOW = 2'h1;
  localparam logic [1:0] RL_HIGH = 2'h2;
  localparam logic [1:0] RL_BOTH = 2'h3;
  localparam logic [1:0] SC_ILLEGAL = 2'h3;
  localparam logic [CTR_W-1:0] CTR_LAST = 16'h0001;

  // Conversion time, a longest time, so the cycle count rounds down
  localparam int CLK_PERIOD_NS = 100;
  localparam int CONV_TIME_US = 8;
  localparam int CONV_CYCLES = (CONV_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int CONV_W = $clog2(CONV_CYCLES + 1);
  localparam logic [CONV_W-1:0] CONV_LOAD = CONV_W'(CONV_CYCLES);
  localparam logic [CONV_W-1:0] CONV_END = CONV_W'(1);

  localparam int BUF_DEPTH = 2;

  typedef enum logic {CONV_IDLE, CONV_RUN} conv_phase_t;

  typedef struct packed {
    logic [CTR_W-1:0] reload;
    logic [CTR_W-1:0] count;
    logic [CTR_W-1:0] latch;
    logic latched;
    logic [1:0] rl;
    logic [2:0] mode;
    logic wr_hi;
    logic rd_hi;
    logic armed;
  } counter_t;
endpackage

// [daq_result_buffer.sv]
// Two-entry result FIFO between the converter and the bus-master port
module daq_result_buffer #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  import daq_pkg::*;

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] PTR_TOP = PTR_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0] wptr;
    logic [PTR_W-1:0] rptr;
    logic [CNT_W-1:0] cnt;
  } buf_state_t;

  buf_state_t s;
  buf_state_t next_s;
  logic push;
  logic pop;

  function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
    return (p == PTR_TOP) ? '0 : p + 1'b1;
  endfunction

  assign in_ready_out = (s.cnt != CNT_FULL);
  assign out_valid_out = (s.cnt != '0);
  assign out_data_out = s.mem[s.rptr];

  always_comb begin
    next_s = s;
    push = in_valid_in && in_ready_out;
    pop = out_valid_out && out_ready_in;
    if (push) begin
      next_s.mem[s.wptr] = in_data_in;
      next_s.wptr = bump(s.wptr);
    end
    if (pop) begin
      next_s.rptr = bump(s.rptr);
    end
    if (push && !pop) begin
      next_s.cnt = s.cnt + 1'b1;
    end else if (pop && !push) begin
      next_s.cnt = s.cnt - 1'b1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

// [daq_trigger_transfer_and_dio.sv]
// Trigger selection, conversion sequencing, result transfer, timer map, D/A and digital I/O
module daq_trigger_transfer_and_dio (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic [daq_pkg::ADDR_W-1:0] host_addr_in,
  input wire logic host_wr_in,
  input wire logic host_rd_in,
  input wire logic [daq_pkg::BE_W-1:0] host_be_in,
  input wire logic [daq_pkg::DATA_W-1:0] host_wdata_in,
  output logic [daq_pkg::DATA_W-1:0] host_rdata_out,
  output logic host_rvalid_out,
  input wire logic edge_trigger_input_in,
  input wire logic [daq_pkg::SAMPLE_W-1:0] adc_sample_in,
  output logic conv_start_out,
  output logic conv_busy_out,
  output logic [daq_pkg::CHAN_W-1:0] adc_channel_out,
  output logic [daq_pkg::CHAN_W-1:0] adc_gain_out,
  output logic irq_out,
  output logic dma_valid_out,
  input wire logic dma_ready_in,
  output logic [daq_pkg::RESULT_W-1:0] dma_data_out,
  output logic [daq_pkg::SAMPLE_W-1:0] dac_code_one_out,
  output logic [daq_pkg::SAMPLE_W-1:0] dac_code_two_out,
  input wire logic [daq_pkg::PORT_W-1:0] input_pins_word_in,
  output logic [daq_pkg::PORT_W-1:0] output_pins_word_out,
  input wire logic timer0_clk_in,
  input wire logic timer0_gate_in,
  output logic timer0_out
);
  import daq_pkg::*;

  typedef struct packed {
    conv_phase_t phase;
    logic [CONV_W-1:0] timer;
    logic start;
    logic [CHAN_W-1:0] sample_chan;
    logic [CHAN_W-1:0] scan_chan;
    logic [RESULT_W-1:0] result;
    logic done;
    logic ovr;
    logic ext_source_select;
    logic pacer_select;
    logic irq_transfer_enable;
    logic bus_master_enable;
    logic autoscan;
    logic [CHAN_W-1:0] mux;
    logic [CHAN_W-1:0] gain;
    logic [2:0] ext_sync;
    logic t0_prev;
    logic t0_out;
    counter_t [2:0] ctr;
    logic pacer_pulse;
    logic [SAMPLE_W-1:0] dac_one;
    logic [SAMPLE_W-1:0] dac_two;
    logic [PORT_W-1:0] dout;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
    logic irq;
    logic push;
    logic [RESULT_W-1:0] push_data;
  } main_state_t;

  main_state_t s;
  main_state_t next_s;
  logic buf_in_ready;
  logic kick;
  logic ext_edge;
  logic trig;
  logic start_go;
  logic complete;
  logic low_read;
  logic ctrl_wr;

  function automatic logic [1:0] ctr_index(input logic [ADDR_W-1:0] a);
    return a[3:2];
  endfunction

  function automatic logic ctr_term(input counter_t c, input logic en);
    return en && c.armed && (c.count == CTR_LAST);
  endfunction

  // Rate-generator style countdown; a reload of zero gives the full 65536 period
  function automatic counter_t ctr_tick(input counter_t c, input logic en);
    counter_t r;
    r = c;
    if (en && c.armed) begin
      r.count = (c.count == CTR_LAST) ? c.reload : c.count - CTR_LAST;
    end
    return r;
  endfunction

  function automatic counter_t ctr_ctrl(input counter_t c, input logic [7:0] b);
    counter_t r;
    r = c;
    if (b[RL_LSB+:2] == RL_LATCH) begin
      if (!c.latched) begin
        r.latch = c.count;
        r.latched = 1'b1;
      end
    end else begin
      r.rl = b[RL_LSB+:2];
      r.mode = b[TMODE_LSB+:3];
      r.wr_hi = 1'b0;
      r.rd_hi = 1'b0;
      r.latched = 1'b0;
      r.armed = 1'b0;
    end
    return r;
  endfunction

  function automatic counter_t ctr_write(input counter_t c, input logic [7:0] b);
    counter_t r;
    r = c;
    case (c.rl)
      RL_LOW: begin
        r.reload = {8'h00, b};
        r.count = {8'h00, b};
        r.armed = 1'b1;
      end
      RL_HIGH: begin
        r.reload = {b, 8'h00};
        r.count = {b, 8'h00};
        r.armed = 1'b1;
      end
      RL_BOTH: begin
        if (!c.wr_hi) begin
          r.reload[7:0] = b;
          r.wr_hi = 1'b1;
          r.armed = 1'b0;
        end else begin
          r.reload[15:8] = b;
          r.count = {b, c.reload[7:0]};
          r.wr_hi = 1'b0;
          r.armed = 1'b1;
        end
      end
      default: r = c;
    endcase
    return r;
  endfunction

  function automatic logic [7:0] ctr_rd_byte(input counter_t c);
    logic [CTR_W-1:0] v;
    v = c.latched ? c.latch : c.count;
    if (c.rl == RL_HIGH || (c.rl == RL_BOTH && c.rd_hi)) begin
      return v[15:8];
    end
    return v[7:0];
  endfunction

  function automatic counter_t ctr_after_read(input counter_t c);
    counter_t r;
    r = c;
    if (c.rl == RL_BOTH) begin
      r.rd_hi = ~c.rd_hi;
    end
    if (c.rl != RL_BOTH || c.rd_hi) begin
      r.latched = 1'b0;
    end
    return r;
  endfunction

  daq_result_buffer #(
    .WIDTH(RESULT_W),
    .DEPTH(BUF_DEPTH)
  ) u_result_buffer (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .in_valid_in(s.push),
    .in_ready_out(buf_in_ready),
    .in_data_in(s.push_data),
    .out_valid_out(dma_valid_out),
    .out_ready_in(dma_ready_in),
    .out_data_out(dma_data_out)
  );

  always_comb begin
    next_s = s;
    next_s.start = 1'b0;
    next_s.push = 1'b0;
    next_s.rvalid = 1'b0;
    ctrl_wr = host_wr_in && (host_addr_in == OFS_AD_CTRL);
    kick = host_wr_in && (host_addr_in == OFS_KICK);
    low_read = host_rd_in && (host_addr_in == OFS_AD_DATA) && host_be_in[0];
    // Only the second and third stages feed the edge detector
    next_s.ext_sync = {s.ext_sync[1:0], edge_trigger_input_in};
    ext_edge = s.ext_sync[1] && !s.ext_sync[2];
    trig = s.ext_source_select ? ext_edge : (s.pacer_select ? s.pacer_pulse : kick);
    start_go = trig && (s.phase == CONV_IDLE);
    complete = (s.phase == CONV_RUN) && (s.timer == CONV_END);

    // Pacer chain: counter 1 every clock, counter 2 on counter 1 terminal
    next_s.ctr[1] = ctr_tick(s.ctr[1], 1'b1);
    next_s.ctr[2] = ctr_tick(s.ctr[2], ctr_term(s.ctr[1], 1'b1));
    next_s.pacer_pulse = ctr_term(s.ctr[2], ctr_term(s.ctr[1], 1'b1));
    next_s.t0_prev = timer0_clk_in;
    next_s.ctr[0] = ctr_tick(s.ctr[0], timer0_clk_in && !s.t0_prev && timer0_gate_in);
    next_s.t0_out = s.ctr[0].armed && (s.ctr[0].count == CTR_LAST);

    if (start_go) begin
      next_s.phase = CONV_RUN;
      next_s.timer = CONV_LOAD;
      next_s.start = 1'b1;
      next_s.sample_chan = s.scan_chan;
    end else if (s.phase == CONV_RUN) begin
      next_s.timer = s.timer - CONV_END;
      if (complete) begin
        next_s.phase = CONV_IDLE;
        next_s.result = {adc_sample_in, s.sample_chan};
        next_s.push = s.bus_master_enable;
        next_s.push_data = {adc_sample_in, s.sample_chan};
        if (s.autoscan) begin
          next_s.scan_chan = (s.scan_chan == '0) ? s.mux : s.scan_chan - 1'b1;
        end
      end
    end

    // Completion wins over a simultaneous low-byte read
    if (complete) begin
      next_s.done = 1'b1;
    end else if (start_go || low_read) begin
      next_s.done = 1'b0;
    end
    next_s.irq = s.irq_transfer_enable && next_s.done;

    // A word that finds the FIFO full is dropped and flagged
    if (s.push && !buf_in_ready) begin
      next_s.ovr = 1'b1;
    end else if (ctrl_wr) begin
      next_s.ovr = 1'b0;
    end

    if (host_wr_in) begin
      case (host_addr_in)
        OFS_CTR0, OFS_CTR1, OFS_CTR2: begin
          next_s.ctr[ctr_index(host_addr_in)] =
            ctr_write(next_s.ctr[ctr_index(host_addr_in)], host_wdata_in[7:0]);
        end
        OFS_TCTRL: begin
          if (host_wdata_in[SC_LSB+:2] != SC_ILLEGAL) begin
            next_s.ctr[host_wdata_in[SC_LSB+:2]] =
              ctr_ctrl(next_s.ctr[host_wdata_in[SC_LSB+:2]], host_wdata_in[7:0]);
          end
        end
        OFS_AD_DATA: next_s.dac_one = host_wdata_in[SAMPLE_W-1:0];
        OFS_DAC_TWO: next_s.dac_two = host_wdata_in[SAMPLE_W-1:0];
        OFS_AD_CTRL: begin
          next_s.bus_master_enable = host_wdata_in[BIT_BUS_MASTER];
          next_s.irq_transfer_enable = host_wdata_in[BIT_IRQ_XFER];
          next_s.pacer_select = host_wdata_in[BIT_PACER];
          next_s.ext_source_select = host_wdata_in[BIT_EXT_SRC];
          next_s.autoscan = host_wdata_in[BIT_AUTOSCAN];
          next_s.mux = host_wdata_in[MUX_LSB+:CHAN_W];
          next_s.gain = host_wdata_in[GAIN_LSB+:CHAN_W];
          next_s.scan_chan = host_wdata_in[MUX_LSB+:CHAN_W];
        end
        OFS_DIO: next_s.dout = host_wdata_in[PORT_W-1:0];
        default: begin
        end
      endcase
    end

    if (host_rd_in) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = '0;
      case (host_addr_in)
        OFS_CTR0, OFS_CTR1, OFS_CTR2: begin
          next_s.rdata = {24'h000000, ctr_rd_byte(s.ctr[ctr_index(host_addr_in)])};
          next_s.ctr[ctr_index(host_addr_in)] =
            ctr_after_read(next_s.ctr[ctr_index(host_addr_in)]);
        end
        OFS_AD_DATA: next_s.rdata = {16'h0000, s.result};
        OFS_AD_CTRL: next_s.rdata = {30'h00000000, s.ovr, s.done};
        OFS_DIO: next_s.rdata = {16'h0000, input_pins_word_in};
        default: next_s.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign host_rdata_out = s.rdata;
  assign host_rvalid_out = s.rvalid;
  assign conv_start_out = s.start;
  assign conv_busy_out = (s.phase == CONV_RUN);
  assign adc_channel_out = s.sample_chan;
  assign adc_gain_out = s.gain;
  assign irq_out = s.irq;
  assign dac_code_one_out = s.dac_one;
  assign dac_code_two_out = s.dac_two;
  assign output_pins_word_out = s.dout;
  assign timer0_out = s.t0_out;

  localparam int CONV_BOUND = CONV_CYCLES;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence seq_soft_kick;
    kick && !s.ext_source_select && !s.pacer_select && (s.phase == CONV_IDLE);
  endsequence
  sequence seq_conv_done;
    ##CONV_BOUND s.done && !conv_busy_out;
  endsequence

  property p_kick_start;
    seq_soft_kick |=> conv_start_out ##1 conv_busy_out;
  endproperty
  a_kick_start: assert property (p_kick_start) else $error("kick did not start");
  property p_busy_not_done;
    conv_busy_out |-> !s.done;
  endproperty
  a_busy_not_done: assert property (p_busy_not_done) else $error("done during conv");
  property p_conv_time;
    $rose(conv_busy_out) |-> seq_conv_done;
  endproperty
  a_conv_time: assert property (p_conv_time) else $error("conversion time wrong");
  property p_ext_ignores;
    (s.ext_source_select && !ext_edge) |=> !conv_start_out;
  endproperty
  a_ext_ignores: assert property (p_ext_ignores) else $error("internal trigger used");
  property p_ext_edge;
    (s.ext_source_select && ext_edge && !conv_busy_out) |=> conv_start_out;
  endproperty
  a_ext_edge: assert property (p_ext_edge) else $error("edge missed");
  property p_one_start;
    conv_start_out |=> !conv_start_out [*8];
  endproperty
  a_one_start: assert property (p_one_start) else $error("conversion restarted");
  property p_read_clears;
    (low_read && !complete) |=> !s.done;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("read kept done");
  property p_irq;
    (s.irq_transfer_enable && complete) |=> irq_out;
  endproperty
  a_irq: assert property (p_irq) else $error("no interrupt");
  property p_overrun;
    (s.push && !buf_in_ready) |=> s.ovr;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");
  property p_dout;
    (host_wr_in && host_addr_in == OFS_DIO) |=> output_pins_word_out == $past(host_wdata_in[15:0]);
  endproperty
  a_dout: assert property (p_dout) else $error("output port not latched");
endmodule

// [daq_trigger_transfer_and_dio_tb.sv]
// Self-checking bench for the DAQ trigger, transfer and digital I/O block
module daq_trigger_transfer_and_dio_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import daq_pkg::*;
  typedef struct {logic w; logic [5:0] a; logic [31:0] d; int sel; logic [15:0] e;} row_t;
  logic clk, rst, wr, rd, ext, stall, rvalid, start, busy, irq, dvalid, dready, t0clk, t0gate, t0out;
  logic [5:0] addr;
  logic [3:0] be, chan, gain;
  logic [31:0] wdata, rdata, rd_word;
  logic [11:0] sample, sval, dac1, dac2;
  logic [15:0] dword, pins_out, last_word, pins_in;
  int words, n_errors, num_checks, starts, busy_cyc, cycles, s0, b0;
  row_t rows[18] = '{
    '{0, 6'h18, 32'h0, 0, 16'h0000},
    '{1, 6'h1C, 32'hFFFF5AC3, 1, 16'h5AC3},
    '{0, 6'h1C, 32'h0, 0, 16'hC35A},
    '{1, 6'h10, 32'h00000ABC, 2, 16'h0ABC},
    '{1, 6'h14, 32'h00001FFF, 3, 16'h0FFF},
    '{0, 6'h24, 32'h0, 0, 16'h0000},
    '{0, 6'h20, 32'h0, 0, 16'h0000},
    '{1, 6'h0C, 32'h30, 4, 16'h0000},
    '{1, 6'h00, 32'h34, 4, 16'h0000},
    '{1, 6'h00, 32'h12, 4, 16'h0000},
    '{0, 6'h00, 32'h0, 0, 16'h0034},
    '{0, 6'h00, 32'h0, 0, 16'h0012},
    '{1, 6'h0C, 32'h74, 4, 16'h0000},
    '{1, 6'h04, 32'h04, 4, 16'h0000},
    '{1, 6'h04, 32'h00, 4, 16'h0000},
    '{1, 6'h0C, 32'hB4, 4, 16'h0000},
    '{1, 6'h08, 32'h02, 4, 16'h0000},
    '{1, 6'h08, 32'h00, 4, 16'h0000}};

  daq_trigger_transfer_and_dio daq_trigger_transfer_and_dio_inst (
    .core_clk_in(clk), .sys_rst_in(rst), .host_addr_in(addr), .host_wr_in(wr),
    .host_rd_in(rd), .host_be_in(be), .host_wdata_in(wdata), .host_rdata_out(rdata),
    .host_rvalid_out(rvalid), .edge_trigger_input_in(ext), .adc_sample_in(sample),
    .conv_start_out(start), .conv_busy_out(busy), .adc_channel_out(chan),
    .adc_gain_out(gain), .irq_out(irq), .dma_valid_out(dvalid), .dma_ready_in(dready),
    .dma_data_out(dword), .dac_code_one_out(dac1), .dac_code_two_out(dac2),
    .input_pins_word_in(pins_in), .output_pins_word_out(pins_out),
    .timer0_clk_in(t0clk), .timer0_gate_in(t0gate), .timer0_out(t0out));

  daq_far_side_model daq_far_side_model_inst (
    .core_clk_in(clk), .sys_rst_in(rst), .conv_busy_in(busy), .sample_value_in(sval),
    .stall_in(stall), .dma_valid_in(dvalid), .dma_data_in(dword),
    .adc_sample_out(sample), .dma_ready_out(dready), .words_out(words),
    .last_word_out(last_word));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (start === 1'b1) starts++;
    if (busy === 1'b1) busy_cyc++;
    // Whole run needs about 1200 cycles
    if (cycles > 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
  endtask

  task automatic rd_reg(input logic [5:0] a);
    @(negedge clk);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    chk(rvalid, 1, "read answer");
    rd_word = rdata;
  endtask

  // Result is ready no later than the fixed conversion time
  task automatic wait_conv();
    repeat (CONV_CYCLES + 6) @(negedge clk);
  endtask

  // Held high across a whole conversion: one edge must give one start
  task automatic ext_edge();
    int n;
    n = starts;
    @(negedge clk);
    ext = 1'b1;
    repeat (5) @(negedge clk);
    chk(starts, n + 1, "edge start");
    wait_conv();
    chk(starts, n + 1, "single start per edge");
    ext = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  initial begin
    rst = 1'b1; wr = 1'b0; rd = 1'b0; ext = 1'b0; stall = 1'b1;
    addr = 6'h00; be = 4'hF; wdata = 32'h0; sval = 12'h5A7;
    t0clk = 1'b0;
    t0gate = 1'b0;
    pins_in = 16'hC35A;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    chk({dvalid, busy, irq, start}, 4'h0, "reset outputs");
    chk(pins_out, 16'h0000, "reset pins");
    foreach (rows[i]) begin
      if (rows[i].w) wr_reg(rows[i].a, rows[i].d);
      else rd_reg(rows[i].a);
      case (rows[i].sel)
        0: chk(rd_word[15:0], rows[i].e, "read value");
        1: chk(pins_out, rows[i].e, "output pins");
        2: chk(dac1, rows[i].e[11:0], "dac one");
        3: chk(dac2, rows[i].e[11:0], "dac two");
        default: ;
      endcase
    end
    pins_in = 16'h3CA5;
    rd_reg(OFS_DIO);
    chk(rd_word[15:0], 16'h3CA5, "input pins");
    // User counter: low byte only, count of 3, two gated clock edges bring it to one
    wr_reg(OFS_TCTRL, 32'h10);
    wr_reg(OFS_CTR0, 32'h03);
    t0gate = 1'b1;
    for (int k = 0; k < 2; k++) begin
      chk(t0out, 1'b0, "user counter early");
      @(negedge clk);
      t0clk = 1'b1;
      @(negedge clk);
      t0clk = 1'b0;
    end
    repeat (2) @(negedge clk);
    chk(t0out, 1'b1, "user counter at one");
    s0 = starts;
    repeat (100) @(negedge clk);
    chk(starts, s0, "pacer idle in soft mode");
    b0 = busy_cyc;
    s0 = starts;
    wr_reg(OFS_KICK, 32'h0);
    repeat (10) @(negedge clk);
    rd_reg(OFS_AD_CTRL);
    chk(rd_word[1:0], 2'h0, "done during conversion");
    wr_reg(OFS_KICK, 32'hFFFFFFFF);
    wait_conv();
    chk(starts, s0 + 1, "kick during busy dropped");
    chk(busy_cyc - b0, CONV_CYCLES, "conversion length");
    rd_reg(OFS_AD_CTRL);
    chk(rd_word[1:0], 2'h1, "done after conversion");
    rd_reg(OFS_AD_DATA);
    chk(rd_word[15:0], {sval, 4'h0}, "result word");
    rd_reg(OFS_AD_CTRL);
    chk(rd_word[0], 1'b0, "done cleared by read");
    wr_reg(OFS_AD_CTRL, 32'h8);
    s0 = starts;
    wr_reg(OFS_KICK, 32'h1);
    repeat (40) @(negedge clk);
    chk(starts, s0, "internal sources ignored");
    sval = 12'h9C1;
    ext_edge();
    chk(irq, 1'b0, "no irq when polled");
    rd_reg(OFS_AD_DATA);
    chk(rd_word[15:0], {sval, 4'h0}, "ext polled result");
    wr_reg(OFS_AD_CTRL, 32'hAA9);
    chk(gain, 4'h5, "gain field");
    repeat (3) ext_edge();
    chk(chan, 4'h5, "dma channel");
    rd_reg(OFS_AD_CTRL);
    chk(rd_word[1], 1'b1, "overrun at full fifo");
    chk(dvalid, 1'b1, "fifo holds words");
    stall = 1'b0;
    repeat (20) @(negedge clk);
    chk(words, 2, "words drained");
    chk(last_word, {sval, 4'h5}, "dma word");
    chk(dvalid, 1'b0, "fifo empty");
    sval = 12'h3E8;
    wr_reg(OFS_AD_CTRL, 32'h46);
    s0 = starts;
    repeat (40) @(negedge clk);
    chk(starts > s0, 1, "pacer start");
    for (int k = 0; k < 120 && busy !== 1'b0; k++) @(negedge clk);
    chk(irq, 1'b1, "irq at done");
    rd_reg(OFS_AD_DATA);
    chk(rd_word[15:0], {sval, 4'h2}, "pacer result");
    wr_reg(OFS_AD_CTRL, 32'h0);
    repeat (90) @(negedge clk);
    // Soft polling with autoscan from channel 1: channels 1, 0, 1
    wr_reg(OFS_AD_CTRL, 32'h30);
    for (int j = 0; j < 3; j++) begin
      wr_reg(OFS_KICK, 32'h0);
      chk(chan, (j == 1) ? 4'h0 : 4'h1, "scan channel");
      rd_word = 32'h0;
      for (int k = 0; k < 60 && rd_word[0] !== 1'b1; k++) rd_reg(OFS_AD_CTRL);
      chk(rd_word[0], 1'b1, "polled done");
      rd_reg(OFS_AD_DATA);
      chk(rd_word[15:0], {sval, ((j == 1) ? 4'h0 : 4'h1)}, "scan result");
    end
    wr_reg(OFS_KICK, 32'h0);
    repeat (20) @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk({busy, irq, dvalid}, 3'h0, "mid-run reset");
    rd_reg(OFS_AD_CTRL);
    chk(rd_word[1:0], 2'h0, "status after reset");
    tally_and_finish();
  end
endmodule
